// *** core/aea_top.sv ***
// Purpose: apparent power and energy per phase
// Assumes: tick, rms and crossings come from the
//          sample logic on CORE_CLK
// Notes:   read data appears one cycle after REG_RD
// Function
// - store scaled rms product per phase
// - apply signed gain, plus minus 100 percent
// - gain C00000 halves, 400000 adds half
// - gain reads upper bits zero, extends
// - no offset term in power path
// - nominal select bits use nominal voltage
// - nominal value 24 bits, top zero
// - integrate per tick, pulse, subtract threshold
// - count pulses, copy on access
// - threshold split high and low words
// - totals signed, wrap to negative
// - pulse changing bit 30 sets half flag
// - enabled half flag pulls interrupt low
// - write one clears flag, line high
// - clear-on-read zeroes total after read
// - wiring code 01 zeroes phase b
// - line mode transfers after crossings
// - line mode enable bit 2
// - bits 5:3 pick crossing phases
//
// block overview
// - each sample tick latches one 24-bit power word per phase
// - each phase owns an integrator that trades power for pulses
// - pulses are counted into 32-bit signed totals
// - totals are read live, cleared on read, or latched in line mode
// - a pulse that changes bit 30 of any counter raises the half-full flag
//
// register word map
// - 00..02 power a..c, read only, sign extended on read
// - 03..05 gain a..c, 24 bits stored, 28-bit extended on read
// - 06 nominal voltage, 24 bits, top byte reads zero
// - 07 / 08 threshold high / low halves, 24 bits each
// - 09..0B energy totals a..c, read only
// - 0C computation config, nominal select in bits 13:11
// - 0D accumulation config, wiring code in bits 5:4
// - 0E line-cycle config: enable, crossing select, clear on read
// - 0F half-cycle count target, zero is treated as one
// - 10 event flags, write one to clear
// - 11 event enables
//
// limitations
// - unmapped reads return zero, unmapped writes are dropped
// - the threshold halves apply at once, so a two-word update
//   runs for at least one cycle with a mixed value; write while idle
// - clear-on-read is ignored while line mode is on
`timescale 1ns/10ps
`include "aea_params.svh"
module aea_top (
  input  wire logic              CORE_CLK,
  input  wire logic              RSTN,
  input  wire logic              SAMPLE_TICK,
  input  wire aea_pkg::aea_rms_t PHASE_RMS,
  input  wire logic [2:0]        ZERO_CROSS,
  input  wire aea_pkg::aea_req_t REG_REQ,
  output logic [31:0]            REG_RDATA,
  output logic                   INTERRUPT_LINE_0_N,
  output logic [2:0]             ENERGY_PULSE
);
  aea_pkg::aea_state_t s_r;   // registered state
  aea_pkg::aea_state_t s_nxt; // next state
  logic [2:0][23:0] pwr_now;  // power this tick
  logic [2:0]       pulse;    // integrator pulses
  logic [2:0]       hit_tot;  // read of a total
  logic             lc_en;    // line mode on
  logic             clr_rd;   // clear-on-read on
  logic             transfer; // line mode copy
  logic             half_ev;  // bit 30 changed
  logic [15:0]      zx_inc;   // crossing count + 1
  logic [15:0]      zx_goal;  // crossings wanted
  logic [31:0]      cnt;      // counter work value
  logic [31:0]      cnt_inc;  // incremented counter

  // rms product to power: scale, then gain.
  // no offset is added here, rms offsets do it
  // the scale constant folds the full-scale power over sixteen
  // and both rms full-scale codes into one multiply and a shift;
  // a single constant costs one product instead of two divides
  // the result is truncated, never rounded, so a small bias of
  // under one lsb is accepted in exchange for less logic
  function automatic logic [23:0] calc_power(
    input logic [23:0] v,
    input logic [23:0] i,
    input logic [23:0] g
  );
    logic [47:0]        prod;
    logic [73:0]        wide;
    logic signed [25:0] base;
    logic signed [27:0] g28;
    logic signed [53:0] adj;
    logic signed [26:0] res;
    prod = v * i;
    wide = 74'(prod) * 74'(`AEA_FS_SCALE);
    base = signed'({1'b0, wide[72:`AEA_SCALE_SHIFT]});
    // gain sign extended to the dsp width
    g28 = signed'({{4{g[23]}}, g});
    adj = 54'(base) * 54'(g28);
    // base * (1 + g / 2^23)
    res = 27'(base) + 27'(adj >>> `AEA_GAIN_FRAC);
    return res[23:0];
  endfunction

  assign lc_en  = s_r.lcyc[`AEA_LC_EN_BIT];
  assign clr_rd = s_r.lcyc[`AEA_CLR_RD_BIT];

  // per-phase power source selection
  // nominal mode swaps the measured voltage for the host value,
  // which keeps metering alive when a voltage input is lost
  // wiring code 01 forces phase b to zero after the selection,
  // so it wins over a nominal select on that phase
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      if (s_r.nom_sel[p]) begin
        pwr_now[p] = calc_power(s_r.nominal,
          PHASE_RMS.irms[p], s_r.gain[p]);
      end else begin
        pwr_now[p] = calc_power(PHASE_RMS.vrms[p],
          PHASE_RMS.irms[p], s_r.gain[p]);
      end
    end
    // two-meter wiring drops phase b
    if (s_r.wiring == `AEA_WIRE_NO_B) begin
      pwr_now[1] = '0;
    end
  end

  // one integrator per phase, common threshold
  // separate integrators keep one phase's residue from leaking
  // into another; the shared threshold keeps their lsb equal
  for (genvar p = 0; p < 3; p++) begin : g_ph
    aea_phase_integrator u_int (
      .clk   (CORE_CLK),
      .rst_n (RSTN),
      .tick  (SAMPLE_TICK),
      .power (signed'(pwr_now[p])),
      .thr   (s_r.thr),
      .pulse (pulse[p])
    );
  end

  // which total is being read this cycle
  // decoded from the live request, so clear-on-read acts on the
  // same edge that captures the read data
  always_comb begin
    hit_tot[0] = REG_REQ.rd && REG_REQ.addr == `AEA_OFS_TOT_A;
    hit_tot[1] = REG_REQ.rd && REG_REQ.addr == `AEA_OFS_TOT_B;
    hit_tot[2] = REG_REQ.rd && REG_REQ.addr == `AEA_OFS_TOT_C;
  end

  // crossing count target, zero treated as one
  // a target of zero would never be reached by an increment,
  // so it is promoted to one rather than stalling line mode
  always_comb begin
    zx_inc  = s_r.zx_cnt + 16'h0001;
    zx_goal = (s_r.hcyc == 16'h0000) ? 16'h0001 : s_r.hcyc;
  end

  // main next-state logic
  // order inside this process matters:
  // - counters are updated before the writes are decoded
  // - a flag set from this cycle's pulse is applied after the
  //   write-one-to-clear, so a new event beats a clear
  // - read data samples the registered state, never s_nxt,
  //   so a read and a write to one word return the old value
  always_comb begin
    s_nxt    = s_r;
    transfer = 1'b0;
    half_ev  = 1'b0;
    cnt      = '0;
    cnt_inc  = '0;

    // latch power registers each tick
    if (SAMPLE_TICK) begin
      s_nxt.power = pwr_now;
    end

    // half-cycle counting in line mode
    if (lc_en) begin
      if (|(ZERO_CROSS & s_r.lcyc[`AEA_ZX_LSB +: 3])) begin
        if (zx_inc >= zx_goal) begin
          s_nxt.zx_cnt = '0;
          transfer = 1'b1;
        end else begin
          s_nxt.zx_cnt = zx_inc;
        end
      end
    end else begin
      // leaving line mode restarts the count
      s_nxt.zx_cnt = '0;
    end

    // pulse counters per phase
    // a pulse landing on the cycle of a clearing read is kept:
    // the counter restarts at zero and then takes the pulse,
    // so no energy is lost across a read-with-reset
    // in line mode the transfer takes the count including any
    // same-cycle pulse, then restarts the count from zero
    for (int p = 0; p < 3; p++) begin
      cnt = s_r.count[p];
      // clear-on-read is not offered in line mode
      if (hit_tot[p] && clr_rd && !lc_en) begin
        cnt = '0;
      end
      cnt_inc = cnt + 32'h0000_0001;
      if (pulse[p]) begin
        // signed wrap past 7FFFFFFF is natural
        if (cnt_inc[`AEA_HALF_TRIP] != cnt[`AEA_HALF_TRIP]) begin
          half_ev = 1'b1;
        end
        cnt = cnt_inc;
      end
      if (lc_en) begin
        if (transfer) begin
          s_nxt.total[p] = cnt;
          cnt = '0;
        end
      end else if (hit_tot[p]) begin
        // copy on access keeps readback coherent
        s_nxt.total[p] = s_r.count[p];
      end
      s_nxt.count[p] = cnt;
    end

    // register writes
    // only the documented field widths are stored; upper write
    // bits are dropped, which gives the zero-padded readback
    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        `AEA_OFS_GAIN_A:  s_nxt.gain[0] = REG_REQ.wdata[23:0];
        `AEA_OFS_GAIN_B:  s_nxt.gain[1] = REG_REQ.wdata[23:0];
        `AEA_OFS_GAIN_C:  s_nxt.gain[2] = REG_REQ.wdata[23:0];
        `AEA_OFS_NOMINAL: s_nxt.nominal = REG_REQ.wdata[23:0];
        `AEA_OFS_THR_HI:  s_nxt.thr[47:24] = REG_REQ.wdata[23:0];
        `AEA_OFS_THR_LO:  s_nxt.thr[23:0] = REG_REQ.wdata[23:0];
        `AEA_OFS_COMP:    s_nxt.nom_sel = REG_REQ.wdata[`AEA_NOM_LSB +: 3];
        `AEA_OFS_ACC:     s_nxt.wiring = REG_REQ.wdata[`AEA_WIRE_LSB +: 2];
        `AEA_OFS_LCYC:    s_nxt.lcyc = REG_REQ.wdata[6:0];
        `AEA_OFS_HCYC:    s_nxt.hcyc = REG_REQ.wdata[15:0];
        `AEA_OFS_ENABLES: s_nxt.enable = REG_REQ.wdata[`AEA_HALF_BIT];
        // write one clears the flag
        `AEA_OFS_FLAGS: begin
          if (REG_REQ.wdata[`AEA_HALF_BIT]) begin
            s_nxt.flag = 1'b0;
          end
        end
        default: ; // unmapped or read-only: ignored
      endcase
    end
    // a new event beats a clear in the same cycle
    if (half_ev) begin
      s_nxt.flag = 1'b1;
    end

    // read data, registered
    // the word stands until the next read strobe, so a slow host
    // may sample it any time after the cycle following the read
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        `AEA_OFS_PWR_A:   s_nxt.rdata = {{8{s_r.power[0][23]}}, s_r.power[0]};
        `AEA_OFS_PWR_B:   s_nxt.rdata = {{8{s_r.power[1][23]}}, s_r.power[1]};
        `AEA_OFS_PWR_C:   s_nxt.rdata = {{8{s_r.power[2][23]}}, s_r.power[2]};
        // gain reads back with four zero msbs
        `AEA_OFS_GAIN_A:  s_nxt.rdata = {4'h0, {4{s_r.gain[0][23]}}, s_r.gain[0]};
        `AEA_OFS_GAIN_B:  s_nxt.rdata = {4'h0, {4{s_r.gain[1][23]}}, s_r.gain[1]};
        `AEA_OFS_GAIN_C:  s_nxt.rdata = {4'h0, {4{s_r.gain[2][23]}}, s_r.gain[2]};
        `AEA_OFS_NOMINAL: s_nxt.rdata = {8'h00, s_r.nominal};
        `AEA_OFS_THR_HI:  s_nxt.rdata = {8'h00, s_r.thr[47:24]};
        `AEA_OFS_THR_LO:  s_nxt.rdata = {8'h00, s_r.thr[23:0]};
        // normal mode returns live count, line mode latched
        `AEA_OFS_TOT_A:   s_nxt.rdata = lc_en ? s_r.total[0] : s_r.count[0];
        `AEA_OFS_TOT_B:   s_nxt.rdata = lc_en ? s_r.total[1] : s_r.count[1];
        `AEA_OFS_TOT_C:   s_nxt.rdata = lc_en ? s_r.total[2] : s_r.count[2];
        `AEA_OFS_COMP:    s_nxt.rdata = 32'(s_r.nom_sel) << `AEA_NOM_LSB;
        `AEA_OFS_ACC:     s_nxt.rdata = 32'(s_r.wiring) << `AEA_WIRE_LSB;
        `AEA_OFS_LCYC:    s_nxt.rdata = {25'h0, s_r.lcyc};
        `AEA_OFS_HCYC:    s_nxt.rdata = {16'h0, s_r.hcyc};
        `AEA_OFS_FLAGS:   s_nxt.rdata = 32'(s_r.flag) << `AEA_HALF_BIT;
        `AEA_OFS_ENABLES: s_nxt.rdata = 32'(s_r.enable) << `AEA_HALF_BIT;
        default:          s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  // reset clears every field: gains, nominal value, threshold,
  // modes, counters, totals and read data all start at zero
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  // the interrupt line is built from two flops, so it cannot
  // glitch; it goes high as soon as either the flag or the
  // enable is cleared
  assign REG_RDATA          = s_r.rdata;
  assign INTERRUPT_LINE_0_N = ~(s_r.flag & s_r.enable);
  assign ENERGY_PULSE       = pulse;
endmodule

// *** core/aea_params.svh ***
// Purpose: named constants for the apparent energy block
// Assumes: included by bare name
// Notes:   definitions only
`ifndef AEA_PARAMS_SVH
`define AEA_PARAMS_SVH
// register word offsets
`define AEA_OFS_PWR_A    8'h00
`define AEA_OFS_PWR_B    8'h01
`define AEA_OFS_PWR_C    8'h02
`define AEA_OFS_GAIN_A   8'h03
`define AEA_OFS_GAIN_B   8'h04
`define AEA_OFS_GAIN_C   8'h05
`define AEA_OFS_NOMINAL  8'h06
`define AEA_OFS_THR_HI   8'h07
`define AEA_OFS_THR_LO   8'h08
`define AEA_OFS_TOT_A    8'h09
`define AEA_OFS_TOT_B    8'h0A
`define AEA_OFS_TOT_C    8'h0B
`define AEA_OFS_COMP     8'h0C
`define AEA_OFS_ACC      8'h0D
`define AEA_OFS_LCYC     8'h0E
`define AEA_OFS_HCYC     8'h0F
`define AEA_OFS_FLAGS    8'h10
`define AEA_OFS_ENABLES  8'h11
// field positions
`define AEA_NOM_LSB      11
`define AEA_WIRE_LSB     4
`define AEA_LC_EN_BIT    2
`define AEA_ZX_LSB       3
`define AEA_CLR_RD_BIT   6
`define AEA_HALF_BIT     4
`define AEA_HALF_TRIP    30
// arithmetic and wiring code
`define AEA_GAIN_FRAC    23
`define AEA_SCALE_SHIFT  48
// full_scale_power_constant/16 * 2^48 / 4191910^2, full_scale_power_constant = 33516139
`define AEA_FS_SCALE     26'd33554431
`define AEA_WIRE_NO_B    2'h1
`endif

// *** core/aea_pkg.sv ***
// Purpose: types shared by the apparent energy block
// Assumes: nothing
// Notes:   constants live in aea_params.svh
package aea_pkg;
  // rms inputs of the three phases, a = index 0
  typedef struct packed {
    logic [2:0][23:0] vrms;
    logic [2:0][23:0] irms;
  } aea_rms_t;
  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } aea_req_t;
  // integrator state
  typedef struct packed {
    logic signed [49:0] acc;
    logic               pulse;
  } aea_int_t;
  // top-level state
  typedef struct packed {
    logic [2:0][23:0] gain;
    logic [23:0]      nominal;
    logic [47:0]      thr;
    logic [2:0]       nom_sel;
    logic [1:0]       wiring;
    logic [6:0]       lcyc;
    logic [15:0]      hcyc;
    logic             flag;
    logic             enable;
    logic [2:0][23:0] power;
    logic [2:0][31:0] count;
    logic [2:0][31:0] total;
    logic [15:0]      zx_cnt;
    logic [31:0]      rdata;
  } aea_state_t;
endpackage

// *** core/aea_phase_integrator.sv ***
// Purpose: one phase threshold integrator
// Assumes: tick is a one-cycle pulse on CORE_CLK
// Notes:   pulse is registered, one cycle wide
`timescale 1ns/10ps
`include "aea_params.svh"
module aea_phase_integrator (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               tick,
  input  wire logic signed [23:0] power,
  input  wire logic [47:0]        thr,
  output logic                    pulse
);
  aea_pkg::aea_int_t s_r;   // registered state
  aea_pkg::aea_int_t s_nxt; // next state
  logic signed [49:0] sum;  // running sum

  // add power each tick, emit one pulse and
  // subtract at threshold
  always_comb begin
    s_nxt = s_r;
    s_nxt.pulse = 1'b0;
    sum = s_r.acc + 50'(power);
    if (tick) begin
      // threshold kept positive: top bits zero
      if (sum >= signed'({2'b00, thr})) begin
        s_nxt.acc = sum - signed'({2'b00, thr});
        s_nxt.pulse = 1'b1;
      end else begin
        s_nxt.acc = sum;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pulse = s_r.pulse;
endmodule

// *** verification/aea_properties.sv ***
// Purpose: port assertions for aea_top
// Assumes: single CORE_CLK domain, reset low
// Notes:   bound to aea_top at the foot of this file
`timescale 1ns/10ps
`include "aea_params.svh"
module aea_properties (
  input wire logic              CORE_CLK,
  input wire logic              RSTN,
  input wire logic              SAMPLE_TICK,
  input wire aea_pkg::aea_req_t REG_REQ,
  input wire logic [31:0]       REG_RDATA,
  input wire logic              INTERRUPT_LINE_0_N,
  input wire logic [2:0]        ENERGY_PULSE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  wire [7:0] adr = REG_REQ.addr; // word offset of the request
  // a pulse only ever answers a tick one edge earlier
  a_pulse_tick: assert property (|ENERGY_PULSE |-> $past(SAMPLE_TICK))
    else $error("pulse without tick");
  // read data stands until the next read
  a_read_hold: assert property (!REG_REQ.rd |=> $stable(REG_RDATA))
    else $error("read data moved");
  a_pwr_sext: assert property (
    REG_REQ.rd && adr <= `AEA_OFS_PWR_C |=> REG_RDATA[31:24] == {8{REG_RDATA[23]}})
    else $error("power not sign extended");
  a_gain_top: assert property (
    REG_REQ.rd && adr >= `AEA_OFS_GAIN_A && adr <= `AEA_OFS_GAIN_C
    |=> REG_RDATA[31:24] == {4'h0, {4{REG_RDATA[23]}}})
    else $error("gain upper bits wrong");
  a_nom_top: assert property (
    REG_REQ.rd && adr == `AEA_OFS_NOMINAL |=> REG_RDATA[31:24] == 8'h00)
    else $error("nominal upper bits set");
  a_thr_top: assert property (
    REG_REQ.rd && (adr == `AEA_OFS_THR_HI || adr == `AEA_OFS_THR_LO) |=> REG_RDATA[31:24] == 8'h00)
    else $error("threshold upper bits set");
  // masking the event releases the line on the next edge
  a_irq_masked: assert property (
    REG_REQ.wr && adr == `AEA_OFS_ENABLES && !REG_REQ.wdata[`AEA_HALF_BIT] |=> INTERRUPT_LINE_0_N)
    else $error("masked line still low");
  // no pulse nearby, so no new set can beat the clear
  a_irq_w1c: assert property (
    REG_REQ.wr && adr == `AEA_OFS_FLAGS && REG_REQ.wdata[`AEA_HALF_BIT] && ENERGY_PULSE == 3'h0
    && $past(ENERGY_PULSE) == 3'h0 |=> INTERRUPT_LINE_0_N)
    else $error("clear left line low");
endmodule
bind aea_top aea_properties aea_properties_inst (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .SAMPLE_TICK(SAMPLE_TICK), .REG_REQ(REG_REQ),
  .REG_RDATA(REG_RDATA), .INTERRUPT_LINE_0_N(INTERRUPT_LINE_0_N), .ENERGY_PULSE(ENERGY_PULSE));

// *** verification/aea_top_tb_top.sv ***
// Purpose: directed bench for aea_top
// Assumes: inputs move 1 ns after the rising edge
// Notes:   half-full needs 2^30 pulses, too long here
`timescale 1ns/10ps
`include "aea_params.svh"
module aea_top_tb_top;
  logic              clk;
  logic              rstn;
  logic              tick;
  aea_pkg::aea_rms_t rms;
  logic [2:0]        zx;
  aea_pkg::aea_req_t req;
  logic [31:0]       rdata;
  logic              irq_n;
  logic [2:0]        pulse;
  int                n_fail;
  int                n_compared;
  int                npb;        // phase b pulses seen
  aea_top aea_top_inst (.CORE_CLK(clk), .RSTN(rstn), .SAMPLE_TICK(tick), .PHASE_RMS(rms), .ZERO_CROSS(zx),
    .REG_REQ(req), .REG_RDATA(rdata), .INTERRUPT_LINE_0_N(irq_n), .ENERGY_PULSE(pulse));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pulse[1] === 1'b1) npb++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
    end
  endtask
  // strobe held one cycle, then one idle cycle so strobes never abut
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk);
    #1 req = {wr, ~wr, adr, d};
    @(posedge clk);
    #1 req = '0;
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    check(rdata, exp);
  endtask
  // tick or crossing, then idle so pulse and count settle
  task automatic strobe(input int n, input logic t, input logic [2:0] z);
    repeat (n) begin
      @(posedge clk);
      #1 tick = t;
      zx = z;
      @(posedge clk);
      #1 tick = 1'b0;
      zx = 3'h0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // the tests need under 1000 cycles, this allows 5000
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    rstn = 1'b0;
    tick = 1'b0;
    zx = 3'h0;
    req = '0;
    rms = '0;
    n_fail = 0;
    n_compared = 0;
    npb = 0;
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    check({31'h0, irq_n}, 32'h1);
    rd(`AEA_OFS_GAIN_A, 32'h0);
    bus(1'b1, `AEA_OFS_THR_HI, 32'hFF7FFFFF);
    rd(`AEA_OFS_THR_HI, 32'h007FFFFF);
    bus(1'b1, `AEA_OFS_NOMINAL, 32'hFF400000);
    rd(`AEA_OFS_NOMINAL, 32'h00400000);
    bus(1'b1, `AEA_OFS_GAIN_B, 32'h00400000);
    bus(1'b1, `AEA_OFS_GAIN_C, 32'hFFC00000);
    rd(`AEA_OFS_GAIN_C, 32'h0FC00000);
    bus(1'b1, `AEA_OFS_PWR_A, 32'h00000055);
    rd(`AEA_OFS_PWR_A, 32'h0);
    rd(8'h20, 32'h0);
    $display("registers done");
    // v = 2^23 makes each scaled product irms - 1 = 3000000
    rms = {{3{24'h800000}}, {3{24'h2DC6C1}}};
    strobe(1, 1'b1, 3'h0);
    rd(`AEA_OFS_PWR_A, 32'h002DC6C0);
    rd(`AEA_OFS_PWR_B, 32'h0044AA20);
    rd(`AEA_OFS_PWR_C, 32'h0016E360);
    // threshold = phase a power; warm-up left each acc at one tick of its own power
    bus(1'b1, `AEA_OFS_THR_LO, 32'h002DC6C0);
    bus(1'b1, `AEA_OFS_THR_HI, 32'h0);
    strobe(4, 1'b1, 3'h0);
    rd(`AEA_OFS_TOT_A, 32'h4);
    rd(`AEA_OFS_TOT_B, 32'h4);
    rd(`AEA_OFS_TOT_C, 32'h2);
    bus(1'b1, `AEA_OFS_LCYC, 32'h40);
    rd(`AEA_OFS_TOT_A, 32'h4);
    rd(`AEA_OFS_TOT_A, 32'h0);
    $display("integration done");
    // nominal 2^22 on phase a, whose own voltage is now zero
    bus(1'b1, `AEA_OFS_COMP, 32'h800);
    rms.vrms[0] = 24'h0;
    strobe(1, 1'b1, 3'h0);
    rd(`AEA_OFS_PWR_A, 32'h0016E360);
    bus(1'b1, `AEA_OFS_ENABLES, 32'h10);
    bus(1'b1, `AEA_OFS_FLAGS, 32'h10);
    rd(`AEA_OFS_FLAGS, 32'h0);
    check({31'h0, irq_n}, 32'h1);
    bus(1'b1, `AEA_OFS_ENABLES, 32'h0);
    $display("nominal and events done");
    // fresh reset so every accumulator starts from zero
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    rms.vrms[0] = 24'h800000;
    rd(`AEA_OFS_THR_HI, 32'h0);
    bus(1'b1, `AEA_OFS_THR_HI, 32'h7FFFFF);
    bus(1'b1, `AEA_OFS_ACC, 32'h10);
    bus(1'b1, `AEA_OFS_LCYC, 32'hC);
    bus(1'b1, `AEA_OFS_HCYC, 32'h2);
    strobe(1, 1'b1, 3'h0);
    bus(1'b1, `AEA_OFS_THR_LO, 32'h2DC6C0);
    bus(1'b1, `AEA_OFS_THR_HI, 32'h0);
    npb = 0;
    strobe(3, 1'b1, 3'h0);
    strobe(2, 1'b0, 3'h2);
    rd(`AEA_OFS_TOT_A, 32'h0);
    strobe(1, 1'b0, 3'h1);
    rd(`AEA_OFS_TOT_A, 32'h0);
    strobe(1, 1'b0, 3'h1);
    rd(`AEA_OFS_TOT_A, 32'h3);
    rd(`AEA_OFS_TOT_C, 32'h3);
    rd(`AEA_OFS_TOT_B, 32'h0);
    check(npb, 32'h0);
    $display("line cycle done");
    end_sim();
  end
endmodule
